// ### design/epg_top.sv
/*
  Digital-to-frequency output stage: turns a filtered real power value into low-rate
  alternating pulses, a calibration pulse train and a reverse-power flag.
  Assumes a 25 MHz ref_clk, a signed power value synchronous to it, and a simple
  register port whose master follows the one-cycle strobe protocol.
*/
`timescale 1ns/100ps
`include "epg_regs.svh"

module epg_top
    import epg_pkg::*;
#(
    parameter int unsigned LOW_PERIOD_CYC = `EPG_LOW_PERIOD_MS * (`EPG_CLK_HZ / 1000),
    parameter int unsigned LOW_WIDTH_CYC = `EPG_LOW_WIDTH_MS * (`EPG_CLK_HZ / 1000),
    parameter int unsigned CAL_PERIOD_CYC = `EPG_CAL_PERIOD_MS * (`EPG_CLK_HZ / 1000),
    parameter int unsigned CAL_WIDTH_CYC = `EPG_CAL_WIDTH_MS * (`EPG_CLK_HZ / 1000)
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire epg_bus_req_type bus_req,
    input wire logic signed [23:0] power_value,
    output logic [31:0] rd_data,
    output logic low_rate_pulse_a_n,
    output logic low_rate_pulse_b_n,
    output logic calibration_pulse_out,
    output logic reverse_power_flag
);

    localparam int ACC_W = 44;
    localparam logic [25:0] OSC_STEP = 26'(`EPG_OSC_HZ);
    localparam logic [25:0] CLK_LIMIT = 26'(`EPG_CLK_HZ);
    // Rounded up, so that a magnitude whose rate lies just under the minimum is still refused.
    localparam logic [23:0] NOLOAD_MIN =
        24'(((longint'(1) << `EPG_FRAC_BITS) * `EPG_NOLOAD_PER_1E7 + 9_999_999) / 10_000_000);
    localparam logic [31:0] HF_WIDTH_CYC =
        32'((`EPG_HF_WIDTH_US * (`EPG_CLK_HZ / 1000) + 999) / 1000);

    // Log2 of the low-rate threshold: base divider plus the power fraction width, less the rate field.
    function automatic logic [5:0] low_shift(input logic [1:0] rate);
        low_shift = 6'(`EPG_BASE_DIV_LOG2 + `EPG_FRAC_BITS) - {4'h0, rate};
    endfunction

    // Log2 of the calibration multiple over the low rate.
    function automatic logic [5:0] cal_log2(input epg_ctrl_type c);
        if (!c.scale && c.rate == 2'b11) begin
            cal_log2 = 6'(`EPG_HF_SCALE_LOG2);
        end else if (c.scale) begin
            cal_log2 = 6'(`EPG_CAL_SCALE_LOG2) - {4'h0, c.rate};
        end else begin
            cal_log2 = 6'(`EPG_CAL_SCALE_LOG2 - 1) - {4'h0, c.rate};
        end
    endfunction

    // Width of a pulse: fixed unless the last interval was short, then half of it.
    function automatic logic [31:0] pulse_width(input logic [31:0] gap, input logic [31:0] period,
                                                input logic [31:0] width);
        logic [31:0] half;
        half = {1'b0, gap[31:1]};
        if (gap >= period) begin
            pulse_width = width;
        end else if (half == 32'h0000_0000) begin
            pulse_width = 32'h0000_0001;
        end else begin
            pulse_width = half;
        end
    endfunction

    epg_ctrl_type ctrl_reg;
    logic [25:0] osc_phase_reg;
    logic osc_tick_reg;
    logic [ACC_W-1:0] low_acc_reg;
    logic [ACC_W-1:0] cal_acc_reg;
    logic [ACC_W-1:0] low_acc_next;
    logic [ACC_W-1:0] cal_acc_next;
    logic [ACC_W-1:0] low_thr;
    logic [ACC_W-1:0] cal_thr;
    logic [23:0] magnitude;
    logic is_negative;
    logic above_noload;
    logic high_freq;
    logic low_fire;
    logic cal_fire;
    logic low_go;
    logic cal_go;
    logic [31:0] low_gap_reg;
    logic [31:0] cal_gap_reg;
    logic [31:0] low_left_reg;
    logic [31:0] cal_left_reg;
    epg_side_type low_side_reg;
    logic [31:0] cal_count_reg;
    logic [31:0] rd_data_reg;
    logic pulse_a_n_reg;
    logic pulse_b_n_reg;
    logic cal_out_reg;
    logic reverse_reg;
    logic [25:0] osc_sum;

    assign high_freq = !ctrl_reg.scale && ctrl_reg.rate == 2'b11;

    // Internal oscillator rate made from ref_clk by a fractional phase accumulator.
    assign osc_sum = osc_phase_reg + OSC_STEP;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            osc_phase_reg <= 26'h000_0000;
            osc_tick_reg <= 1'b0;
        end else if (osc_sum >= CLK_LIMIT) begin
            osc_phase_reg <= osc_sum - CLK_LIMIT;
            osc_tick_reg <= 1'b1;
        end else begin
            osc_phase_reg <= osc_sum;
            osc_tick_reg <= 1'b0;
        end
    end

    // Thresholds set by the base divider and the calibration scale.
    always_comb begin
        low_thr = ACC_W'(1) << low_shift(ctrl_reg.rate);
        cal_thr = low_thr >> cal_log2(ctrl_reg);
    end

    always_comb begin
        is_negative = power_value[23];
        magnitude = is_negative ? 24'(-power_value) : 24'(power_value);
        above_noload = magnitude >= NOLOAD_MIN;
        low_acc_next = low_acc_reg;
        cal_acc_next = cal_acc_reg;
        low_fire = 1'b0;
        cal_fire = 1'b0;
        if (osc_tick_reg && above_noload && !is_negative) begin
            low_acc_next = low_acc_reg + ACC_W'(magnitude);
        end
        if (osc_tick_reg && above_noload) begin
            cal_acc_next = cal_acc_reg + ACC_W'(magnitude);
        end
        if (low_acc_next >= low_thr) begin
            low_acc_next = low_acc_next - low_thr;
            low_fire = 1'b1;
        end
        if (cal_acc_next >= cal_thr) begin
            cal_acc_next = cal_acc_next - cal_thr;
            cal_fire = 1'b1;
        end
        low_go = low_fire && !reverse_reg;
        cal_go = cal_fire && !is_negative;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_acc_reg <= '0;
            cal_acc_reg <= '0;
        end else begin
            low_acc_reg <= low_acc_next;
            cal_acc_reg <= cal_acc_next;
        end
    end

    // The flag follows the sign of power only when the calibration accumulator crosses its threshold, pulse issued or not.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reverse_reg <= 1'b0;
        end else if (cal_fire) begin
            reverse_reg <= is_negative;
        end
    end

    // Low-rate pulse shaping with alternation between the two outputs.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_gap_reg <= 32'hFFFF_FFFF;
            low_left_reg <= 32'h0000_0000;
            low_side_reg <= EPG_SIDE_A;
            pulse_a_n_reg <= 1'b1;
            pulse_b_n_reg <= 1'b1;
        end else if (low_go) begin
            low_gap_reg <= 32'h0000_0001;
            low_left_reg <= pulse_width(low_gap_reg, 32'(LOW_PERIOD_CYC), 32'(LOW_WIDTH_CYC)) - 32'h1;
            pulse_a_n_reg <= low_side_reg != EPG_SIDE_A;
            pulse_b_n_reg <= low_side_reg != EPG_SIDE_B;
            low_side_reg <= (low_side_reg == EPG_SIDE_A) ? EPG_SIDE_B : EPG_SIDE_A;
        end else begin
            if (low_gap_reg != 32'hFFFF_FFFF) begin
                low_gap_reg <= low_gap_reg + 32'h1;
            end
            if (low_left_reg != 32'h0000_0000) begin
                low_left_reg <= low_left_reg - 32'h1;
            end else begin
                pulse_a_n_reg <= 1'b1;
                pulse_b_n_reg <= 1'b1;
            end
        end
    end

    // Calibration pulse shaping.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cal_gap_reg <= 32'hFFFF_FFFF;
            cal_left_reg <= 32'h0000_0000;
            cal_out_reg <= 1'b0;
        end else if (cal_go) begin
            cal_gap_reg <= 32'h0000_0001;
            if (high_freq) begin
                cal_left_reg <= HF_WIDTH_CYC - 32'h1;
            end else begin
                cal_left_reg <= pulse_width(cal_gap_reg, 32'(CAL_PERIOD_CYC), 32'(CAL_WIDTH_CYC)) - 32'h1;
            end
            cal_out_reg <= 1'b1;
        end else begin
            if (cal_gap_reg != 32'hFFFF_FFFF) begin
                cal_gap_reg <= cal_gap_reg + 32'h1;
            end
            if (cal_left_reg != 32'h0000_0000) begin
                cal_left_reg <= cal_left_reg - 32'h1;
            end else begin
                cal_out_reg <= 1'b0;
            end
        end
    end

    // Running count of issued calibration pulses for energy readout.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cal_count_reg <= 32'h0000_0000;
        end else if (cal_go) begin
            cal_count_reg <= cal_count_reg + 32'h1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `EPG_CTRL_RESET;
        end else if (bus_req.wr && bus_req.addr == `EPG_CTRL_OFFSET) begin
            ctrl_reg.rate[0] <= bus_req.wdata[`EPG_CTRL_RATE_LSB_BIT];
            ctrl_reg.rate[1] <= bus_req.wdata[`EPG_CTRL_RATE_MSB_BIT];
            ctrl_reg.scale <= bus_req.wdata[`EPG_CTRL_SCALE_BIT];
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_data_reg <= 32'h0000_0000;
        end else if (!bus_req.rd) begin
            rd_data_reg <= 32'h0000_0000;
        end else if (bus_req.addr == `EPG_CTRL_OFFSET) begin
            rd_data_reg <= 32'h0000_0000;
            rd_data_reg[`EPG_CTRL_RATE_LSB_BIT] <= ctrl_reg.rate[0];
            rd_data_reg[`EPG_CTRL_RATE_MSB_BIT] <= ctrl_reg.rate[1];
            rd_data_reg[`EPG_CTRL_SCALE_BIT] <= ctrl_reg.scale;
        end else if (bus_req.addr == `EPG_STATUS_OFFSET) begin
            rd_data_reg <= 32'h0000_0000;
            rd_data_reg[`EPG_STATUS_REVERSE_BIT] <= reverse_reg;
            rd_data_reg[`EPG_STATUS_HIGH_FREQ_BIT] <= high_freq;
            rd_data_reg[`EPG_STATUS_PULSE_A_BIT] <= !pulse_a_n_reg;
            rd_data_reg[`EPG_STATUS_PULSE_B_BIT] <= !pulse_b_n_reg;
            rd_data_reg[`EPG_STATUS_CAL_BIT] <= cal_out_reg;
        end else if (bus_req.addr == `EPG_COUNT_OFFSET) begin
            rd_data_reg <= cal_count_reg;
        end else begin
            rd_data_reg <= 32'h0000_0000;
        end
    end

    assign rd_data = rd_data_reg;
    assign low_rate_pulse_a_n = pulse_a_n_reg;
    assign low_rate_pulse_b_n = pulse_b_n_reg;
    assign calibration_pulse_out = cal_out_reg;
    assign reverse_power_flag = reverse_reg;

endmodule

// ### design/epg_regs.svh
/*
  Register offsets, field positions, reset values and timing figures of the energy pulse output generator.
  Assumes inclusion by bare name from the design files; holds definitions only.
*/
`ifndef EPG_REGS_SVH
`define EPG_REGS_SVH

`define EPG_CTRL_OFFSET 8'h00
`define EPG_STATUS_OFFSET 8'h04
`define EPG_COUNT_OFFSET 8'h08

`define EPG_CTRL_RESET 3'h0
`define EPG_CTRL_RATE_LSB_BIT 0
`define EPG_CTRL_RATE_MSB_BIT 1
`define EPG_CTRL_SCALE_BIT 2

`define EPG_STATUS_REVERSE_BIT 0
`define EPG_STATUS_HIGH_FREQ_BIT 1
`define EPG_STATUS_PULSE_A_BIT 2
`define EPG_STATUS_PULSE_B_BIT 3
`define EPG_STATUS_CAL_BIT 4

`define EPG_CLK_HZ 25_000_000
`define EPG_OSC_HZ 450_000
`define EPG_BASE_DIV_LOG2 19
`define EPG_FRAC_BITS 23
`define EPG_NOLOAD_PER_1E7 244
`define EPG_CAL_SCALE_LOG2 7
`define EPG_HF_SCALE_LOG2 11

`define EPG_LOW_PERIOD_MS 240
`define EPG_LOW_WIDTH_MS 120
`define EPG_CAL_PERIOD_MS 180
`define EPG_CAL_WIDTH_MS 90
`define EPG_HF_WIDTH_US 35

`endif

// ### design/epg_pkg.sv
/*
  Types shared by the energy pulse output generator.
  Assumes the offsets and timing figures come from epg_regs.svh.
*/
package epg_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } epg_bus_req_type;

    typedef struct packed {
        logic scale;
        logic [1:0] rate;
    } epg_ctrl_type;

    typedef enum logic {
        EPG_SIDE_A,
        EPG_SIDE_B
    } epg_side_type;

endpackage

// ### verification/epg_top_properties.sv
/*
  Bound checker of the energy pulse output generator ports.
  Assumes rising ref_clk edges and rst asynchronous, active high.
*/
`timescale 1ns/100ps
module epg_chk
    import epg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire epg_bus_req_type bus_req,
    input wire logic [31:0] rd_data,
    input wire logic low_rate_pulse_a_n,
    input wire logic low_rate_pulse_b_n,
    input wire logic calibration_pulse_out,
    input wire logic reverse_power_flag
);
    logic [2:0] ctrl_reg;
    logic next_a_reg;
    logic [11:0] high_reg;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Shadows the mode, the next low-rate side and the high time of the calibration pulse.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= 3'h0;
            next_a_reg <= 1'b1;
            high_reg <= 12'h000;
        end else begin
            if (bus_req.wr && bus_req.addr == 8'h00) begin
                ctrl_reg <= bus_req.wdata[2:0];
            end
            if ($fell(low_rate_pulse_a_n) || $fell(low_rate_pulse_b_n)) begin
                next_a_reg <= !$fell(low_rate_pulse_a_n);
            end
            high_reg <= calibration_pulse_out ? high_reg + 12'h001 : 12'h000;
        end
    end
    idle_after_reset_a: assert property (
        $fell(rst) |-> low_rate_pulse_a_n && low_rate_pulse_b_n && !calibration_pulse_out && !reverse_power_flag)
        else $error("outputs not idle after reset");
    reverse_blocks_a: assert property (
        $rose(calibration_pulse_out) || $fell(low_rate_pulse_a_n) || $fell(low_rate_pulse_b_n) |-> !reverse_power_flag)
        else $error("pulse while reverse flag high");
    flag_clear_cal_a: assert property (
        $fell(reverse_power_flag) |-> $rose(calibration_pulse_out))
        else $error("flag cleared without calibration pulse");
    hf_cal_width_a: assert property (
        ctrl_reg == 3'h3 && $fell(calibration_pulse_out) |-> high_reg == 12'h36b)
        else $error("bad high frequency pulse width");
    low_alternate_a: assert property (
        ($fell(low_rate_pulse_a_n) |-> next_a_reg) and ($fell(low_rate_pulse_b_n) |-> !next_a_reg))
        else $error("low-rate pulses not alternating");
    ctrl_readback_a: assert property (
        bus_req.rd && bus_req.addr == 8'h00 |=> rd_data == {29'h0000_0000, $past(ctrl_reg)})
        else $error("bad control readback");
    status_mode_a: assert property (
        bus_req.rd && bus_req.addr == 8'h04 |=> rd_data[1:0] == {$past(ctrl_reg) == 3'h3, $past(reverse_power_flag)})
        else $error("bad status bits");
    unmapped_zero_a: assert property (
        bus_req.rd && !(bus_req.addr inside {8'h00, 8'h04, 8'h08}) |=> rd_data == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule
bind epg_top epg_chk epg_chk_i (.ref_clk, .rst, .bus_req, .rd_data, .low_rate_pulse_a_n, .low_rate_pulse_b_n,
    .calibration_pulse_out, .reverse_power_flag);

// ### verification/epg_counter_model.sv
/*
  Pulse counter standing in for the metering controller on the calibration output.
  Assumes an active-high calibration output sampled on ref_clk.
*/
`timescale 1ns/100ps
module epg_counter_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic calibration_pulse_out,
    output logic [31:0] cal_count
);
    logic last_reg;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            last_reg <= 1'b0;
            cal_count <= 32'h0000_0000;
        end else begin
            last_reg <= calibration_pulse_out;
            cal_count <= cal_count + 32'(calibration_pulse_out && !last_reg);
        end
    end
endmodule

// ### verification/epg_tb_top.sv
/*
  Self-checking testbench of the energy pulse output generator.
  Assumes epg_top, its bound checker and the counter model are compiled first.
*/
`timescale 1ns/100ps
`include "epg_regs.svh"
module epg_tb_top
    import epg_pkg::*;
();
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    epg_bus_req_type bus_req = '0;
    logic signed [23:0] power_value = 24'h00_0000;
    logic [31:0] rd_data;
    logic low_rate_pulse_a_n;
    logic low_rate_pulse_b_n;
    logic calibration_pulse_out;
    logic reverse_power_flag;
    logic [31:0] cal_count;
    logic [31:0] c;
    logic [23:0] v;
    int unsigned n;
    int unsigned w;
    int mismatches = 0;
    int num_checks = 0;

    epg_top #(.LOW_PERIOD_CYC(200), .LOW_WIDTH_CYC(100), .CAL_PERIOD_CYC(160), .CAL_WIDTH_CYC(80)) epg_top_i (
        .ref_clk, .rst, .bus_req, .power_value, .rd_data, .low_rate_pulse_a_n, .low_rate_pulse_b_n,
        .calibration_pulse_out, .reverse_power_flag);
    epg_counter_model epg_counter_model_i (.ref_clk, .rst, .calibration_pulse_out, .cal_count);

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    // Rise-to-rise cycles of high frequency calibration pulses for a steady positive sample.
    function automatic int unsigned hf_period(input logic [23:0] s);
        return ((32'h1000_0000 / s) * `EPG_CLK_HZ) / `EPG_OSC_HZ;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge ref_clk);
        bus_req <= '{a, dat, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        @(negedge ref_clk);
        chk(rd_data, exp);
    endtask

    task automatic wait_lvl(input logic l, output int unsigned k);
        for (k = 0; k < 8000 && calibration_pulse_out !== l; k++) begin
            @(negedge ref_clk);
        end
    endtask

    task automatic setp(input logic [23:0] s);
        @(posedge ref_clk);
        power_value <= s;
        @(negedge ref_clk);
    endtask

    task automatic results;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #4_000_000;
        mismatches++;
        results();
    end

    initial begin
        void'($urandom(32'ha9dd));
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rchk(8'h08, 32'h0000_0000);
        chk({30'h0000_0000, low_rate_pulse_a_n, low_rate_pulse_b_n}, 32'h0000_0003);
        for (int i = 0; i < 8; i++) begin
            wr(8'h00, 32'(i));
            rchk(8'h00, 32'(i));
            rchk(8'h04, {30'h0000_0000, i == 3, 1'b0});
        end
        wr(8'h08, 32'hffff_ffff);
        rchk(8'h08, 32'h0000_0000);
        repeat (4) begin
            rchk(8'(($urandom % 240) + 16), 32'h0000_0000);
        end
        wr(8'h00, 32'h0000_0003);
        repeat (3) begin
            v = 24'($urandom_range(32'h007f_ffff, 32'h0040_0000));
            setp(v);
            wait_lvl(1'b0, w);
            wait_lvl(1'b1, n);
            wait_lvl(1'b0, w);
            chk(w, `EPG_HF_WIDTH_US * (`EPG_CLK_HZ / 1_000_000));
            rchk(8'h08, cal_count);
            wait_lvl(1'b1, n);
            chk(32'(w + n + 120 > hf_period(v) && w + n < hf_period(v) + 120), 32'h0000_0001);
            chk(32'(reverse_power_flag), 32'h0000_0000);
        end
        setp(~v + 24'h00_0001);
        c = cal_count;
        for (n = 0; n < 8000 && reverse_power_flag !== 1'b1; n++) begin
            @(negedge ref_clk);
        end
        rchk(8'h04, 32'h0000_0003);
        repeat (4000) @(negedge ref_clk);
        chk(cal_count, c);
        chk(32'(reverse_power_flag), 32'h0000_0001);
        setp(v);
        wait_lvl(1'b1, n);
        chk(32'(reverse_power_flag), 32'h0000_0000);
        wait_lvl(1'b0, w);
        setp(24'h00_00cc);
        c = cal_count;
        repeat (4000) @(negedge ref_clk);
        chk(cal_count, c);
        chk({30'h0000_0000, low_rate_pulse_a_n, low_rate_pulse_b_n}, 32'h0000_0003);
        results();
    end
endmodule
